// ===== ubc_params.svh
`ifndef UBC_PARAMS_SVH
`define UBC_PARAMS_SVH
// register indices, byte address is four times the index
`define UBC_IDX_SERIAL_PORT_CONTROL 8'h98
`define UBC_IDX_SERIAL_DATA_BUFFER 8'h99
`define UBC_IDX_BFRAC 8'h9d
`define UBC_IDX_BCTL 8'h9e
`define UBC_IDX_CFG 8'haf
`define UBC_IDX_TIMER2_CONTROL 8'hc8
`define UBC_IDX_RLD_LO 8'hca
`define UBC_IDX_RLD_HI 8'hcb
`define UBC_IDX_ISTAT 8'hf0
`define UBC_IDX_IMASK 8'hf1
`define UBC_RST_BYTE 8'h00
`define UBC_RST_INT 6'h00
// serial_port_control fields
`define UBC_SC_MODE9 7
`define UBC_SC_FCHK 5
`define UBC_SC_REN 4
`define UBC_SC_TB9 3
`define UBC_SC_RB9 2
`define UBC_SC_TI 1
`define UBC_SC_RI 0
// baud_control_and_errors fields
`define UBC_BC_DIV 2:0
`define UBC_BC_EXT 4:3
`define UBC_BC_OE 5
`define UBC_BC_BE 6
`define UBC_BC_FE 7
`define UBC_BC_SW_MASK 8'h1f
`define UBC_CFG_ENHANCED_RECEIVE_ENABLE 0
`define UBC_CFG_CAREN 1
`define UBC_T2_RCLK 5
`define UBC_T2_TX_RATE_FROM_TIMER2 4
`define UBC_T2_RUN 2
// interrupt status bits
`define UBC_IS_RX 0
`define UBC_IS_TX 1
`define UBC_IS_FE 2
`define UBC_IS_BE 3
`define UBC_IS_OE 4
`define UBC_IS_WAKE 5
// timing
`define UBC_FRAC_ONE 8'd64
`define UBC_TICK_LAST 4'hf
`define UBC_TICK_MID 4'h7
`define UBC_BREAK_TICKS 8'd176
`define UBC_CLK_HZ 25000000
`define UBC_CARRIER_HZ 38000
`define UBC_CAR_HALF 9'(`UBC_CLK_HZ / (2 * `UBC_CARRIER_HZ))
`define UBC_FRAME8 4'd10
`define UBC_FRAME9 4'd11
`define UBC_LAST_D8 4'd7
`define UBC_LAST_D9 4'd8
`define UBC_TX_STOP_LEFT 4'd2
`define UBC_TX_LAST 4'd1
`define UBC_PRE_W 10
`endif

// ===== ubc_pkg.sv
`default_nettype none
`include "ubc_params.svh"
package ubc_pkg;
  typedef enum logic [3:0] {
    UBC_RX_IDLE = 4'b0001,
    UBC_RX_START = 4'b0010,
    UBC_RX_DATA = 4'b0100,
    UBC_RX_STOP = 4'b1000
  } ubc_rx_state_t;
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ubc_ahb_req_t;
  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ubc_ahb_rsp_t;
  typedef struct packed {
    logic [7:0] serial_port_control, serial_data_buffer, baudFrac, baudCtl, cfg, timer2_control, rldLo, rldHi;
    logic [5:0] intStat, intMask;
    logic wrPend;
    logic [7:0] wrIdx;
    logic [31:0] rdata;
    logic t2Half;
    logic [15:0] t2Count;
    logic [`UBC_PRE_W-1:0] preCount;
    logic [7:0] fracAcc;
    logic [8:0] carCount;
    logic carrier, txBusy, txd;
    logic [3:0] txTick, txBits;
    logic [10:0] txShift;
    logic [1:0] rxSync;
    logic rxPrev, wake;
    ubc_rx_state_t rxState;
    logic [3:0] rxTick, rxBits;
    logic [8:0] rxShift;
    logic [7:0] breakCount;
  } ubc_state_t;
endpackage
`default_nettype wire

// ===== ubc_uart_baud_and_error_check.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "ubc_params.svh"
module ubc_uart_baud_and_error_check import ubc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire ubc_ahb_req_t ahbReq,
  output ubc_ahb_rsp_t ahbRsp,
  // serial line
  input wire logic rxdPin,
  output logic txd,
  // system events
  output logic irq,
  output logic rxWake
);
  ubc_state_t st;
  ubc_state_t next_st;

  logic addrOk, selAny, readReq, accept;
  logic [7:0] reqIdx;
  logic t2Run, t2Ovf, prePulse, baudTick, txTickEn, rxTickEn;
  logic [3:0] expo;
  logic [`UBC_PRE_W-1:0] preMask;
  logic mode9, rxd, stopSample, rxBitEnd, txBitEnd;

  assign reqIdx = ahbReq.haddr[9:2];
  assign addrOk = (ahbReq.haddr[31:10] == 22'h000000);
  assign selAny = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
  // hready left out so ready never feeds back on itself
  assign readReq = ahbReq.hsel && ahbReq.htrans[1] && !ahbReq.hwrite;
  // a read right behind a write waits one cycle so it sees the new value
  assign ahbRsp.hreadyout = !(st.wrPend && readReq);
  assign ahbRsp.hresp = 1'b0;
  assign ahbRsp.hrdata = st.rdata;
  assign accept = selAny && ahbRsp.hreadyout;

  assign t2Run = st.timer2_control[`UBC_T2_RUN]
    && (st.timer2_control[`UBC_T2_RCLK] || st.timer2_control[`UBC_T2_TX_RATE_FROM_TIMER2]);
  assign t2Ovf = t2Run && st.t2Half && (st.t2Count == 16'hffff);
  assign expo = 4'(st.baudCtl[`UBC_BC_DIV])
    + 4'(st.baudCtl[`UBC_BC_EXT]);
  assign preMask = `UBC_PRE_W'((11'h001 << expo) - 11'h001);
  assign prePulse = ((st.preCount | ~preMask) == '1);
  assign baudTick = prePulse
    && ((st.fracAcc + `UBC_FRAC_ONE)
        >= (`UBC_FRAC_ONE + {2'b00, st.baudFrac[5:0]}));
  assign txTickEn = st.timer2_control[`UBC_T2_TX_RATE_FROM_TIMER2] ? t2Ovf : baudTick;
  assign rxTickEn = st.timer2_control[`UBC_T2_RCLK] ? t2Ovf : baudTick;

  assign mode9 = st.serial_port_control[`UBC_SC_MODE9];
  assign rxd = st.rxSync[1];
  assign rxBitEnd = rxTickEn && (st.rxTick == `UBC_TICK_LAST);
  assign stopSample = rxBitEnd && (st.rxState == UBC_RX_STOP);
  assign txBitEnd = st.txBusy && txTickEn
    && (st.txTick == `UBC_TICK_LAST);

  assign txd = st.txd;
  assign rxWake = st.wake;
  assign irq = |(st.intStat & st.intMask);

  always_comb begin
    logic [7:0] wd;
    logic [7:0] rv;
    logic [7:0] accNew;
    logic [7:0] rxByte;
    logic ninth, qualified, take, txLine;
    wd = ahbReq.hwdata[7:0];
    rv = 8'h00;
    accNew = 8'h00;
    rxByte = 8'h00;
    ninth = 1'b0;
    qualified = 1'b0;
    take = 1'b0;
    txLine = 1'b1;
    next_st = st;
    // write data phase
    if (st.wrPend) begin
      case (st.wrIdx)
        `UBC_IDX_SERIAL_PORT_CONTROL: next_st.serial_port_control = wd;
        `UBC_IDX_BFRAC: next_st.baudFrac = wd;
        `UBC_IDX_BCTL: begin
          next_st.baudCtl = (wd & `UBC_BC_SW_MASK)
            | (st.baudCtl & ~`UBC_BC_SW_MASK);
          // framing and break error flags clear by writing zero, writing one keeps them
          next_st.baudCtl[`UBC_BC_FE] = st.baudCtl[`UBC_BC_FE]
            && wd[`UBC_BC_FE];
          next_st.baudCtl[`UBC_BC_BE] = st.baudCtl[`UBC_BC_BE]
            && wd[`UBC_BC_BE];
        end
        `UBC_IDX_CFG: next_st.cfg = wd;
        `UBC_IDX_TIMER2_CONTROL: next_st.timer2_control = wd;
        `UBC_IDX_RLD_LO: next_st.rldLo = wd;
        `UBC_IDX_RLD_HI: next_st.rldHi = wd;
        `UBC_IDX_IMASK: next_st.intMask = wd[5:0];
        `UBC_IDX_SERIAL_DATA_BUFFER: begin
          if (!st.txBusy) begin
            next_st.txBusy = 1'b1;
            next_st.txTick = 4'h0;
            next_st.txShift = {1'b1, mode9 ? st.serial_port_control[`UBC_SC_TB9] : 1'b1,
              wd, 1'b0};
            next_st.txBits = mode9 ? `UBC_FRAME9 : `UBC_FRAME8;
          end
        end
        default: next_st.serial_port_control = next_st.serial_port_control;
      endcase
    end
    next_st.wrPend = 1'b0;
    // address phase
    if (accept) begin
      if (ahbReq.hwrite) begin
        next_st.wrPend = addrOk;
        next_st.wrIdx = reqIdx;
      end else begin
        if (addrOk) begin
          case (reqIdx)
            `UBC_IDX_SERIAL_PORT_CONTROL: rv = st.serial_port_control;
            `UBC_IDX_SERIAL_DATA_BUFFER: rv = st.serial_data_buffer;
            `UBC_IDX_BFRAC: rv = st.baudFrac;
            `UBC_IDX_BCTL: rv = st.baudCtl;
            `UBC_IDX_CFG: rv = st.cfg;
            `UBC_IDX_TIMER2_CONTROL: rv = st.timer2_control;
            `UBC_IDX_RLD_LO: rv = st.rldLo;
            `UBC_IDX_RLD_HI: rv = st.rldHi;
            `UBC_IDX_ISTAT: rv = {2'b00, st.intStat};
            `UBC_IDX_IMASK: rv = {2'b00, st.intMask};
            default: rv = 8'h00;
          endcase
          if (reqIdx == `UBC_IDX_SERIAL_DATA_BUFFER) begin
            next_st.baudCtl[`UBC_BC_OE] = 1'b0;
          end
          if (reqIdx == `UBC_IDX_ISTAT) begin
            next_st.intStat = `UBC_RST_INT;
          end
        end
        next_st.rdata = {24'h000000, rv};
      end
    end
    // timer 2 baud generator
    if (t2Run) begin
      next_st.t2Half = !st.t2Half;
      if (st.t2Half) begin
        next_st.t2Count = t2Ovf ? {st.rldHi, st.rldLo}
          : st.t2Count + 16'h0001;
      end
    end else begin
      next_st.t2Half = 1'b0;
      // stopped timer sits at reload so the first bit is full length
      next_st.t2Count = {st.rldHi, st.rldLo};
    end
    // dedicated baud timer, skipping prescaled pulses on the fraction
    next_st.preCount = st.preCount + `UBC_PRE_W'(1);
    if (prePulse) begin
      accNew = st.fracAcc + `UBC_FRAC_ONE;
      next_st.fracAcc = baudTick
        ? accNew - (`UBC_FRAC_ONE + {2'b00, st.baudFrac[5:0]})
        : accNew;
    end
    // carrier
    if (st.carCount == `UBC_CAR_HALF - 9'd1) begin
      next_st.carCount = 9'd0;
      next_st.carrier = !st.carrier;
    end else begin
      next_st.carCount = st.carCount + 9'd1;
    end
    // transmitter
    if (st.txBusy && txTickEn) begin
      next_st.txTick = st.txTick + 4'h1;
    end
    if (txBitEnd) begin
      next_st.txShift = {1'b1, st.txShift[10:1]};
      next_st.txBits = st.txBits - 4'd1;
      if (st.txBits == `UBC_TX_STOP_LEFT) begin
        next_st.serial_port_control[`UBC_SC_TI] = 1'b1;
        next_st.intStat[`UBC_IS_TX] = 1'b1;
      end
      if (st.txBits == `UBC_TX_LAST) begin
        next_st.txBusy = 1'b0;
      end
    end
    txLine = next_st.txBusy ? next_st.txShift[0] : 1'b1;
    next_st.txd = txLine
      || (st.cfg[`UBC_CFG_CAREN] && st.carrier);
    // receiver
    next_st.rxSync = {st.rxSync[0], rxdPin};
    next_st.rxPrev = rxd;
    next_st.wake = st.rxPrev && !rxd;
    if (st.wake) begin
      next_st.intStat[`UBC_IS_WAKE] = 1'b1;
    end
    if (rxTickEn && (st.rxState != UBC_RX_IDLE)) begin
      next_st.rxTick = st.rxTick + 4'h1;
    end
    case (st.rxState)
      UBC_RX_IDLE: begin
        if (st.rxPrev && !rxd && st.serial_port_control[`UBC_SC_REN]) begin
          next_st.rxState = UBC_RX_START;
          next_st.rxTick = 4'h0;
        end
      end
      UBC_RX_START: begin
        if (rxTickEn && (st.rxTick == `UBC_TICK_MID)) begin
          next_st.rxTick = 4'h0;
          next_st.rxBits = 4'h0;
          next_st.rxState = rxd ? UBC_RX_IDLE : UBC_RX_DATA;
        end
      end
      UBC_RX_DATA: begin
        if (rxBitEnd) begin
          next_st.rxShift = {rxd, st.rxShift[8:1]};
          next_st.rxBits = st.rxBits + 4'h1;
          if (st.rxBits == (mode9 ? `UBC_LAST_D9 : `UBC_LAST_D8)) begin
            next_st.rxState = UBC_RX_STOP;
          end
        end
      end
      UBC_RX_STOP: begin
        if (stopSample) begin
          next_st.rxState = UBC_RX_IDLE;
          rxByte = mode9 ? st.rxShift[7:0] : st.rxShift[8:1];
          ninth = mode9 ? st.rxShift[8] : rxd;
          qualified = !st.serial_port_control[`UBC_SC_FCHK] || ninth;
          take = qualified && (st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE]
            || !st.serial_port_control[`UBC_SC_RI]);
          if (take) begin
            next_st.serial_data_buffer = rxByte;
            next_st.serial_port_control[`UBC_SC_RB9] = ninth;
            next_st.serial_port_control[`UBC_SC_RI] = 1'b1;
            next_st.intStat[`UBC_IS_RX] = 1'b1;
            if (st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE] && st.serial_port_control[`UBC_SC_RI]) begin
              next_st.baudCtl[`UBC_BC_OE] = 1'b1;
              next_st.intStat[`UBC_IS_OE] = 1'b1;
            end
          end
          if (st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE] && !rxd) begin
            next_st.baudCtl[`UBC_BC_FE] = 1'b1;
            next_st.intStat[`UBC_IS_FE] = 1'b1;
          end
        end
      end
      default: next_st.rxState = UBC_RX_IDLE;
    endcase
    // break watch counts 16x ticks while the line stays low
    if (rxd || !st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE]) begin
      next_st.breakCount = 8'd0;
    end else if (rxTickEn && (st.breakCount != `UBC_BREAK_TICKS)) begin
      next_st.breakCount = st.breakCount + 8'd1;
      if (st.breakCount == `UBC_BREAK_TICKS - 8'd1) begin
        next_st.baudCtl[`UBC_BC_BE] = 1'b1;
        next_st.intStat[`UBC_IS_BE] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.rxState <= UBC_RX_IDLE;
      st.txd <= 1'b1;
      st.txShift <= '1;
      st.rxSync <= 2'b11;
      st.rxPrev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  AST_T2_HALF: assert property (@(posedge clk) disable iff (rst)
    (t2Run && !st.t2Half) |=> $stable(st.t2Count))
    else $error("timer 2 advanced on consecutive clocks");

  AST_T2_RELOAD: assert property (@(posedge clk) disable iff (rst)
    t2Ovf |=> (st.t2Count == {$past(st.rldHi), $past(st.rldLo)}))
    else $error("timer 2 did not reload on overflow");

  AST_TX_BIT: assert property (@(posedge clk) disable iff (rst)
    (st.txBusy && $past(st.txBusy) && (st.txBits != $past(st.txBits)))
      |-> ($past(st.txTick) == 4'hf && $past(txTickEn)))
    else $error("tx bit advanced before sixteen ticks");

  AST_OE_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (accept && !ahbReq.hwrite && addrOk && reqIdx == `UBC_IDX_SERIAL_DATA_BUFFER
      && !stopSample) |=> !st.baudCtl[`UBC_BC_OE])
    else $error("buffer read did not clear overwrite error");

  AST_DISCARD: assert property (@(posedge clk) disable iff (rst)
    (stopSample && !st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE] && st.serial_port_control[`UBC_SC_RI]
      && !st.wrPend) |=> $stable(st.serial_data_buffer))
    else $error("frame overwrote unread buffer");

  AST_FRAME_ERR: assert property (@(posedge clk) disable iff (rst)
    (stopSample && st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE] && !rxd)
      |=> st.baudCtl[`UBC_BC_FE] && st.intStat[`UBC_IS_FE])
    else $error("missing stop bit not flagged");

  AST_NO_ERR: assert property (@(posedge clk) disable iff (rst)
    !st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE]
      |=> !$rose(st.baudCtl[`UBC_BC_FE]) && !$rose(st.baudCtl[`UBC_BC_BE]))
    else $error("error flag set with enhanced receive off");

  AST_BREAK: assert property (@(posedge clk) disable iff (rst)
    (rxTickEn && !rxd && st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE]
      && st.breakCount == `UBC_BREAK_TICKS - 8'd1)
      |=> st.baudCtl[`UBC_BC_BE] && st.breakCount == `UBC_BREAK_TICKS)
    else $error("long low line not flagged as break");

  AST_FCHK: assert property (@(posedge clk) disable iff (rst)
    (stopSample && st.serial_port_control[`UBC_SC_FCHK] && !mode9 && !rxd
      && !st.serial_port_control[`UBC_SC_RI] && !st.wrPend) |=> !st.serial_port_control[`UBC_SC_RI])
    else $error("frame without stop bit accepted");

  AST_OVERWRITE: assert property (@(posedge clk)
    disable iff (rst)
    (stopSample && st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE] && st.serial_port_control[`UBC_SC_RI]
      && !st.serial_port_control[`UBC_SC_FCHK]) |=> st.baudCtl[`UBC_BC_OE])
    else $error("overwrite of unread byte not flagged");

  AST_RX_TAKE: assert property (@(posedge clk)
    disable iff (rst)
    (stopSample && st.cfg[`UBC_CFG_ENHANCED_RECEIVE_ENABLE] && !st.serial_port_control[`UBC_SC_FCHK]
      && !mode9) |=> (st.serial_data_buffer == $past(st.rxShift[8:1])))
    else $error("enhanced receiver dropped a frame");

  AST_STOP_NINTH: assert property (@(posedge clk)
    disable iff (rst)
    (stopSample && !mode9 && !st.serial_port_control[`UBC_SC_FCHK]
      && !st.serial_port_control[`UBC_SC_RI] && !st.wrPend)
      |=> (st.serial_port_control[`UBC_SC_RB9] == $past(rxd)))
    else $error("stop bit not kept as ninth bit");

  AST_PRESCALE: assert property (@(posedge clk)
    disable iff (rst)
    (prePulse && (expo != 4'h0) && !st.wrPend) |=> !prePulse)
    else $error("prescaler pulsed on consecutive clocks");

  AST_CARRIER: assert property (@(posedge clk)
    disable iff (rst)
    (st.cfg[`UBC_CFG_CAREN] && st.carrier) |=> txd)
    else $error("carrier high not seen on transmit line");

  AST_CAR_HALF: assert property (@(posedge clk)
    disable iff (rst)
    (st.carCount == `UBC_CAR_HALF - 9'd1)
      |=> (st.carrier != $past(st.carrier)))
    else $error("carrier did not toggle at half period");

  AST_TXD_IDLE: assert property (@(posedge clk)
    disable iff (rst)
    (!st.txBusy && !st.wrPend) |=> txd)
    else $error("transmit line low while idle");

  AST_WAKE: assert property (@(posedge clk)
    disable iff (rst)
    $fell(rxd) |=> rxWake ##1 (!rxWake && st.intStat[`UBC_IS_WAKE]))
    else $error("receive line activity gave no wake event");

  AST_RX_T2: assert property (@(posedge clk)
    disable iff (rst)
    (st.timer2_control[`UBC_T2_RCLK] && !t2Ovf && (st.rxState != UBC_RX_IDLE))
      |=> $stable(st.rxTick))
    else $error("receiver ticked without a timer 2 overflow");

  AST_TX_T2: assert property (@(posedge clk)
    disable iff (rst)
    (st.timer2_control[`UBC_T2_TX_RATE_FROM_TIMER2] && !t2Ovf && st.txBusy && !st.wrPend)
      |=> $stable(st.txTick))
    else $error("transmitter ticked without a timer 2 overflow");

endmodule // ubc_uart_baud_and_error_check
`default_nettype wire

// ===== ubc_serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ubc_serial_peer (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // start, nb bits lsb first, then stop at the given level
  task automatic send(input logic [8:0] d, input int nb,
    input logic stop, input int cyc);
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge clk) rxd <= (i == 0) ? 1'b0 : (i > nb) ? stop : d[i-1];
      repeat (cyc - 1) @(posedge clk);
    end
    @(posedge clk) rxd <= 1'b1;
  endtask
  // line held low past a whole frame
  task automatic hold_low(input int cyc);
    @(posedge clk) rxd <= 1'b0;
    repeat (cyc) @(posedge clk);
    rxd <= 1'b1;
  endtask
  // mid-bit sampling of one byte from the device
  task automatic grab(input int cyc, output logic [7:0] d);
    for (int k = 0; k < 5000 && txd !== 1'b0; k++) @(negedge clk);
    repeat (cyc / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (cyc) @(negedge clk);
      d[i] = txd;
    end
  endtask
endmodule // ubc_serial_peer
`default_nettype wire

// ===== ubc_uart_baud_and_error_check_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ubc_params.svh"
module ubc_uart_baud_and_error_check_tb import ubc_pkg::*;;
  typedef struct {logic [7:0] a, w, e;} ubc_reg_t;
  typedef struct {logic [7:0] bc, bf, t2; int n, tol;} ubc_row_t;
  logic clk, rst, rxd, txd, irq, rxWake;
  ubc_ahb_req_t mreq, busIn;
  ubc_ahb_rsp_t ahbRsp;
  int errors = 0, n_checks = 0, wakes = 0, n;
  logic [7:0] rd, b;
  ubc_reg_t regs[10] = '{'{8'h9d, 8'h2b, 8'h2b}, '{8'h9e, 8'h1f, 8'h1f},
    '{8'hca, 8'ha5, 8'ha5}, '{8'hcb, 8'h5a, 8'h5a}, '{8'hf1, 8'h3f, 8'h3f},
    '{8'hf0, 8'h3f, 8'h00}, '{8'h00, 8'hff, 8'h00}, '{8'haf, 8'h00, 8'h00},
    '{8'hc8, 8'h00, 8'h00}, '{8'h98, 8'h40, 8'h40}};
  ubc_row_t rows[4] = '{'{8'h00, 8'h00, 8'h00, 144, 2},
    '{8'h11, 8'h00, 8'h00, 1152, 16},
    '{8'h01, 8'h20, 8'h00, 432, 6},
    '{8'h00, 8'h00, 8'h14, 576, 8}};

  ubc_uart_baud_and_error_check i_ubc_uart_baud_and_error_check (
    .clk(clk), .rst(rst), .ahbReq(busIn), .ahbRsp(ahbRsp),
    .rxdPin(rxd), .txd(txd), .irq(irq), .rxWake(rxWake));
  ubc_serial_peer i_ubc_serial_peer (.clk(clk), .txd(txd), .rxd(rxd));

  always_comb begin
    busIn = mreq;
    busIn.hready = ahbRsp.hreadyout;
  end
  always @(posedge clk) if (rxWake === 1'b1) wakes <= wakes + 1;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_near(input string nm, input int e, g, tol);
    n_checks++;
    if (g < e - tol || g > e + tol) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // waits for hready in mid-cycle, then ends on the edge
  task automatic bus_wait(output logic [31:0] d);
    int k;
    k = 0;
    @(negedge clk);
    while (ahbRsp.hreadyout !== 1'b1 && k < 50) begin
      k++;
      @(negedge clk);
    end
    if (ahbRsp.hreadyout !== 1'b1) errors++;
    d = ahbRsp.hrdata;
    @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, wd,
    output logic [7:0] r);
    logic [31:0] d;
    mreq.hsel <= 1'b1;
    mreq.haddr <= {22'h0, a, 2'b00};
    mreq.htrans <= 2'b10;
    mreq.hwrite <= w;
    mreq.hsize <= 3'b010;
    bus_wait(d);
    mreq.htrans <= 2'b00;
    mreq.hwdata <= {24'h0, wd};
    bus_wait(d);
    r = d[7:0];
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, e);
    bus(1'b0, a, 8'h00, rd);
    chk(nm, e, rd);
  endtask
  task automatic send(input logic [8:0] d, input int nb, input logic s);
    i_ubc_serial_peer.send(d, nb, s, 16);
    repeat (4) @(posedge clk);
  endtask
  task automatic low_time(output int c);
    c = 0;
    for (int k = 0; k < 9000 && txd !== 1'b0; k++) @(negedge clk);
    while (txd === 1'b0 && c < 9000) begin
      c++;
      @(negedge clk);
    end
    repeat (c / 4) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    mreq = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("txd idle", 1'b1, txd);
    foreach (regs[i]) begin
      rdc("reset", regs[i].a, 8'h00);
      wr(regs[i].a, regs[i].w);
      rdc("readback", regs[i].a, regs[i].e);
    end
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'hff);
    foreach (rows[i]) begin
      wr(8'h9e, rows[i].bc);
      wr(8'h9d, rows[i].bf);
      wr(8'hc8, rows[i].t2);
      wr(8'h99, 8'h00);
      low_time(n);
      chk_near("low time", rows[i].n, n, rows[i].tol);
    end
    rdc("tx done", 8'h98, 8'h42);
    chk("irq on", 1'b1, irq);
    rdc("status", 8'hf0, 8'h02);
    chk("irq off", 1'b0, irq);
    wr(8'hc8, 8'h00);
    wr(8'h9e, 8'h00);
    wr(8'h9d, 8'h00);
    fork
      wr(8'h99, 8'h5a);
      i_ubc_serial_peer.grab(16, b);
    join
    chk("tx byte", 8'h5a, b);
    repeat (64) @(posedge clk);
    wr(8'h9e, 8'h04);
    wr(8'haf, 8'h02);
    wr(8'h99, 8'h00);
    n = 0;
    b[0] = txd;
    repeat (2700) begin
      @(negedge clk);
      if (b[0] === 1'b0 && txd === 1'b1) n++;
      b[0] = txd;
    end
    @(posedge clk);
    chk_near("carrier rises", 4, n, 1);
    wr(8'haf, 8'h00);
    wr(8'h9e, 8'h00);
    wr(8'hf1, 8'h00);
    wr(8'h98, 8'h10);
    send(9'h0a7, 8, 1'b1);
    rdc("rx byte", 8'h99, 8'ha7);
    rdc("rx flags", 8'h98, 8'h15);
    chk("wakes", 3, wakes);
    chk("irq masked", 1'b0, irq);
    rdc("rx status", 8'hf0, 8'h23);
    send(9'h03c, 8, 1'b1);
    rdc("kept byte", 8'h99, 8'ha7);
    rdc("no overwrite", 8'h9e, 8'h00);
    wr(8'haf, 8'h01);
    send(9'h03c, 8, 1'b1);
    rdc("overwrite", 8'h9e, 8'h20);
    rdc("new byte", 8'h99, 8'h3c);
    rdc("overwrite clr", 8'h9e, 8'h00);
    wr(8'h98, 8'h10);
    send(9'h055, 8, 1'b0);
    rdc("frame err 8", 8'h9e, 8'h80);
    rdc("no stop", 8'h98, 8'h11);
    wr(8'h9e, 8'h00);
    wr(8'h98, 8'h90);
    send(9'h155, 9, 1'b0);
    rdc("frame err 9", 8'h9e, 8'h80);
    wr(8'h9e, 8'h00);
    wr(8'h98, 8'h30);
    send(9'h066, 8, 1'b0);
    rdc("rejected", 8'h98, 8'h30);
    rdc("old byte", 8'h99, 8'h55);
    wr(8'haf, 8'h00);
    wr(8'h9e, 8'h00);
    wr(8'h98, 8'h10);
    send(9'h066, 8, 1'b0);
    rdc("plain mode", 8'h9e, 8'h00);
    wr(8'haf, 8'h01);
    wr(8'hf1, 8'h08);
    i_ubc_serial_peer.hold_low(208);
    repeat (40) @(posedge clk);
    chk("break irq", 1'b1, irq);
    bus(1'b0, 8'h9e, 8'h00, rd);
    chk("break", 8'h40, rd & 8'h40);
    rdc("clear", 8'hf0, 8'h3d);
    chk("irq clear", 1'b0, irq);
    wr(8'hca, 8'hff);
    wr(8'hcb, 8'hff);
    wr(8'hc8, 8'h24);
    i_ubc_serial_peer.send(9'h0c3, 8, 1'b1, 32);
    repeat (4) @(posedge clk);
    rdc("t2 rx", 8'h99, 8'hc3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rdc("mask rst", 8'hf1, 8'h00);
    rdc("ctl rst", 8'h9e, 8'h00);
    chk("irq rst", 1'b0, irq);
    report_and_stop;
  end
endmodule // ubc_uart_baud_and_error_check_tb
`default_nettype wire
